// file: core/tts_core.sv
/*
  Outbound transfer sequencer: paces, counts, fetches each item from the
  processor, aligns it in scratch RAM and writes it to host memory.
  Assumes the processor side bus and host DMA bus share clk, and an
  Avalon-MM master with waitrequest reaches the RAM and registers.
*/
// Function
// - Pace by incrementing delay until bit 13 clears
// - Buffer item in slot 13, then DMA out
// - Check parity on RAM output after store
// - Keep only low 16 bits of item
// - Load delay from slot 0, drive address 16-17
// - Stay in delay state until bit 13 zero
// - Load count slot 7; zero ends and interrupts
// - Nonzero count: increment, write back to 7
// - Fetch byte via interrupt dialogue into buffer
// - Function word code 6, direction bit 0
// - Shift buffer left while loading address
// - Byte mode high half: swap halves
// - Store item in data slot, then DMA write
// - Null stop: still write, end, no address increment
// - Address plus one byte, two word, next item
// - Count bit 13 latched as byte mode
`timescale 1ns/1ps
`default_nettype none
module tts_core
  import tts_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tts_pbus_in_t pbus_in,
  output logic fn_req,
  output logic [35:0] fn_word,
  output tts_dma_out_t dma_out,
  input wire logic dma_ack,
  output logic host_irq
);
  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TTS_IDLE, TTS_LOAD_DLY, TTS_DLY_INC, TTS_LOAD_CNT, TTS_CNT_INC,
    TTS_FETCH, TTS_SHIFT, TTS_STORE, TTS_DMA, TTS_ADR_INC
  } tts_state_t;

  tts_state_t state_ff; // Sequencer state
  tts_state_t nxt_state; // Next state
  logic [15:0] ram_ff [RAM_WORDS]; // Scratch RAM
  logic [15:0] abc_ff; // Address/count register
  logic [1:0] hadr_ff; // Host address bits 16-17
  logic [35:0] ebuf_ff; // Wide data buffer
  logic par_ff; // Parity received with the item
  logic chk_ff; // Parity check pending
  logic byte_mode_ff; // Byte mode control flip-flop
  logic null_stop_ff; // Stop on null this cycle
  logic run_ff; // Software run enable
  logic done_ff; // Outbound done, sticky
  logic perr_ff; // Parity error, sticky
  logic ack_ff; // Bus answer strobe
  logic [31:0] rdata_ff; // Registered read data
  logic fsm_we; // Sequencer writes RAM this cycle
  logic [3:0] fsm_slot; // Slot the sequencer writes
  logic [15:0] fsm_wdata; // Data the sequencer writes
  logic [15:0] store_item; // Aligned item for the data slot
  logic bus_wr; // Bus write takes effect
  logic cnt_zero; // Byte count field is zero
  logic null_hit; // Stored item is a null
  logic end_null; // Null stop ends the transfer
  logic set_done; // Event setting the done flag
  logic set_perr; // Event setting the parity flag

  // Merge bus write lanes into a 16-bit word
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] be);
    lane_merge = old;
    if (be[0]) begin
      lane_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction

  // Sequencer states that take the RAM write port
  function automatic logic owns_ram(input tts_state_t s);
    owns_ram = (s == TTS_CNT_INC) || (s == TTS_STORE) ||
        (s == TTS_ADR_INC);
  endfunction

  // ---------------------------------------------------------------
  // Datapath decisions
  // ---------------------------------------------------------------
  // Only buffer bits 04-19 reach the RAM, so wide items lose bits
  assign store_item = (byte_mode_ff && abc_ff[0]) ?
      {ebuf_ff[23:16], ebuf_ff[31:24]} : ebuf_ff[31:16];
  assign cnt_zero = (ram_ff[SLOT_CNT][CNT_FIELD_W-1:0] == '0);
  assign null_hit = byte_mode_ff ? (ram_ff[SLOT_DAT][7:0] == 8'h00) :
      (ram_ff[SLOT_DAT] == 16'h0000);
  assign end_null = (state_ff == TTS_DMA) && dma_ack && null_stop_ff &&
      null_hit;
  assign set_done = ((state_ff == TTS_LOAD_CNT) && cnt_zero) ||
      end_null;
  assign set_perr = chk_ff && ((^ram_ff[SLOT_DAT]) != par_ff);

  // RAM write port owner; the bus waits while the sequencer writes
  always_comb begin
    fsm_we = 1'b0;
    fsm_slot = SLOT_CNT;
    fsm_wdata = abc_ff;
    unique case (state_ff)
      TTS_CNT_INC: begin
        fsm_we = 1'b1;
        fsm_wdata = {abc_ff[15:CNT_FIELD_W],
            abc_ff[CNT_FIELD_W-1:0] + 1'b1};
      end
      TTS_STORE: begin
        fsm_we = 1'b1;
        fsm_slot = SLOT_DAT;
        fsm_wdata = store_item;
      end
      TTS_ADR_INC: begin
        fsm_we = 1'b1;
        fsm_slot = SLOT_ADR;
        fsm_wdata = abc_ff + (byte_mode_ff ? ADR_STEP_BYTE :
            ADR_STEP_WORD);
      end
      default: begin
        fsm_we = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TTS_IDLE: if (run_ff) nxt_state = TTS_LOAD_DLY;
      TTS_LOAD_DLY: nxt_state = TTS_DLY_INC;
      TTS_DLY_INC: if (!abc_ff[DLY_STOP_BIT]) begin
        nxt_state = TTS_LOAD_CNT;
      end
      TTS_LOAD_CNT: nxt_state = cnt_zero ? TTS_IDLE : TTS_CNT_INC;
      TTS_CNT_INC: nxt_state = TTS_FETCH;
      TTS_FETCH: if (pbus_in.ack) nxt_state = TTS_SHIFT;
      TTS_SHIFT: nxt_state = TTS_STORE;
      TTS_STORE: nxt_state = TTS_DMA;
      TTS_DMA: if (dma_ack) begin
        nxt_state = end_null ? TTS_IDLE : TTS_ADR_INC;
      end
      TTS_ADR_INC: nxt_state = run_ff ? TTS_LOAD_DLY : TTS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= TTS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address/count register and high address bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abc_ff <= 16'h0000;
      hadr_ff <= 2'h0;
    end else begin
      unique case (state_ff)
        TTS_LOAD_DLY: begin
          abc_ff <= ram_ff[SLOT_DLY];
          hadr_ff <= ram_ff[SLOT_DLY][DLY_HADR_LO+1:DLY_HADR_LO];
        end
        TTS_DLY_INC: if (abc_ff[DLY_STOP_BIT]) begin
          abc_ff <= abc_ff + 16'h0001;
        end
        TTS_LOAD_CNT: abc_ff <= ram_ff[SLOT_CNT];
        TTS_CNT_INC: abc_ff <= fsm_wdata;
        TTS_SHIFT: abc_ff <= ram_ff[SLOT_ADR];
        TTS_ADR_INC: abc_ff <= fsm_wdata;
        default: begin
          abc_ff <= abc_ff;
        end
      endcase
    end
  end

  // Wide buffer: capture from the processor, then shift into place
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ebuf_ff <= 36'h000000000;
      par_ff <= 1'b0;
    end else if (state_ff == TTS_FETCH && pbus_in.ack) begin
      ebuf_ff <= pbus_in.data;
      par_ff <= pbus_in.par;
    end else if (state_ff == TTS_SHIFT) begin
      ebuf_ff <= {ebuf_ff[19:0], 16'h0000};
    end
  end

  // Null stop option, sampled with the byte count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      null_stop_ff <= 1'b0;
    end else if (state_ff == TTS_LOAD_CNT) begin
      null_stop_ff <= ram_ff[SLOT_CNT][CNT_NULL_BIT];
    end
  end

  // Parity check runs one cycle after the store strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_ff <= 1'b0;
    end else begin
      chk_ff <= (state_ff == TTS_STORE);
    end
  end

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  assign bus_wr = ack_ff && avs_write;
  assign avs_waitrequest = !ack_ff;
  assign avs_readdata = rdata_ff;

  // One-cycle answer, held off while the sequencer owns the RAM
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      // Look one cycle ahead, so a bus write never meets a sequencer write
      ack_ff <= (avs_read || avs_write) && !ack_ff && !owns_ram(nxt_state);
      if (avs_address < REG_CTRL) begin
        rdata_ff <= {16'h0000, ram_ff[avs_address[3:0]]};
      end else if (avs_address == REG_CTRL) begin
        rdata_ff <= {31'h00000000, run_ff};
      end else if (avs_address == REG_STAT) begin
        rdata_ff <= {28'h0000000, byte_mode_ff, state_ff != TTS_IDLE,
            perr_ff, done_ff};
      end else begin
        rdata_ff <= 32'h00000000; // Unmapped reads as zero
      end
    end
  end

  // Scratch RAM; no reset, as in the storage it models
  always_ff @(posedge clk) begin
    if (fsm_we) begin
      ram_ff[fsm_slot] <= fsm_wdata;
    end else if (bus_wr && avs_address < REG_CTRL) begin
      ram_ff[avs_address[3:0]] <= lane_merge(ram_ff[avs_address[3:0]],
          avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  // Byte mode flip-flop follows the last count word written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_mode_ff <= 1'b0;
    end else if (bus_wr && avs_address == {1'b0, SLOT_CNT} &&
        avs_byteenable[1]) begin
      byte_mode_ff <= avs_writedata[CNT_BYTE_BIT];
    end
  end

  // Run enable; a finished transfer drops it until software restarts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_ff <= 1'b0;
    end else if (set_done) begin
      run_ff <= 1'b0;
    end else if (bus_wr && avs_address == REG_CTRL && avs_byteenable[0]) begin
      run_ff <= avs_writedata[CTRL_RUN];
    end
  end

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
      perr_ff <= 1'b0;
    end else begin
      if (set_done) begin
        done_ff <= 1'b1;
      end else if (bus_wr && avs_address == REG_STAT &&
          avs_writedata[STAT_DONE] && avs_byteenable[0]) begin
        done_ff <= 1'b0;
      end
      if (set_perr) begin
        perr_ff <= 1'b1;
      end else if (bus_wr && avs_address == REG_STAT &&
          avs_writedata[STAT_PERR] && avs_byteenable[0]) begin
        perr_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outward buses
  // ---------------------------------------------------------------
  assign host_irq = done_ff;
  assign fn_req = (state_ff == TTS_FETCH);
  always_comb begin
    fn_word = 36'h000000000;
    fn_word[FN_CODE_HI:FN_CODE_LO] = FN_BYTE_XFER;
    fn_word[FN_DIR_BIT] = FN_DIR_OUT;
  end
  assign dma_out.req = (state_ff == TTS_DMA);
  assign dma_out.byte_wr = byte_mode_ff;
  assign dma_out.addr = {hadr_ff, abc_ff};
  assign dma_out.data = ram_ff[SLOT_DAT];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_dly_pace: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_DLY_INC && abc_ff[DLY_STOP_BIT]
      |=> state_ff == TTS_DLY_INC && abc_ff == $past(abc_ff) + 16'h0001)
    else $error("delay did not step");
  a_dly_exit: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_DLY_INC && !abc_ff[DLY_STOP_BIT]
      |=> state_ff == TTS_LOAD_CNT)
    else $error("delay did not end");
  a_hadr_load: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_LOAD_DLY |=> dma_out.addr[17:16] ==
      $past(ram_ff[SLOT_DLY][DLY_HADR_LO+1:DLY_HADR_LO]))
    else $error("high address not loaded");
  a_cnt_zero: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_LOAD_CNT && cnt_zero
      |=> done_ff && host_irq && state_ff == TTS_IDLE)
    else $error("zero count did not finish");
  a_cnt_back: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_CNT_INC |=> ram_ff[SLOT_CNT][CNT_FIELD_W-1:0] ==
      $past(abc_ff[CNT_FIELD_W-1:0]) + 1'b1)
    else $error("count not written back");
  a_fn_code: assert property (@(posedge clk) disable iff (sys_rst)
    fn_req |-> fn_word[FN_CODE_HI:FN_CODE_LO] == 3'h6 &&
      !fn_word[FN_DIR_BIT])
    else $error("bad function word");
  a_buf_shift: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_SHIFT |=> ebuf_ff[31:16] == $past(ebuf_ff[15:0]) &&
      abc_ff == $past(ram_ff[SLOT_ADR]))
    else $error("shift or address load wrong");
  a_half_swap: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_STORE && byte_mode_ff && abc_ff[0]
      |=> ram_ff[SLOT_DAT][15:8] == $past(ebuf_ff[23:16]))
    else $error("byte not swapped");
  a_par_flag: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_STORE ##1 (^ram_ff[SLOT_DAT]) != par_ff
      |=> perr_ff)
    else $error("parity error missed");
  a_null_stop: assert property (@(posedge clk) disable iff (sys_rst)
    end_null |=> state_ff == TTS_IDLE && done_ff &&
      abc_ff == $past(abc_ff))
    else $error("null stop wrong");
  a_adr_step: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == TTS_ADR_INC |=> ram_ff[SLOT_ADR] == $past(abc_ff) +
      ($past(byte_mode_ff) ? 16'h0001 : 16'h0002))
    else $error("address step wrong");
endmodule
`default_nettype wire

// file: shared/tts_pkg.sv
/*
  Shared constants and carriers for the outbound transfer sequencer.
  Assumes one clock domain; the processor side bus and the host memory
  bus are driven by logic running on that same clock.
*/
`default_nettype none
package tts_pkg;
  // ---------------------------------------------------------------
  // Scratch RAM layout
  // ---------------------------------------------------------------
  localparam int RAM_WORDS = 16; // Scratch RAM depth
  localparam logic [3:0] SLOT_DLY = 4'h0; // Pacing delay word
  localparam logic [3:0] SLOT_CNT = 4'h7; // Outbound byte count
  localparam logic [3:0] SLOT_ADR = 4'hB; // Outbound host address
  localparam logic [3:0] SLOT_DAT = 4'hD; // Outbound data slot
  // ---------------------------------------------------------------
  // Register bus map (word index)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h10; // Control: bit 0 run
  localparam logic [4:0] REG_STAT = 5'h11; // Status, write 1 clears
  localparam int CTRL_RUN = 0; // Run enable
  localparam int STAT_DONE = 0; // Outbound done
  localparam int STAT_PERR = 1; // Parity error
  localparam int STAT_BUSY = 2; // Sequencer not idle
  localparam int STAT_BYTE = 3; // Byte mode flip-flop
  // ---------------------------------------------------------------
  // Word fields
  // ---------------------------------------------------------------
  localparam int DLY_STOP_BIT = 13; // Delay done when this is zero
  localparam int DLY_HADR_LO = 14; // High address bits of delay word
  localparam int CNT_FIELD_W = 13; // Byte count field width
  localparam int CNT_BYTE_BIT = 13; // Byte mode select
  localparam int CNT_NULL_BIT = 14; // Stop on null character
  // Interrupt function word, bit 0 is the MSB of the 36-bit word
  localparam int FN_CODE_HI = 32; // Word bits 03-05
  localparam int FN_CODE_LO = 30;
  localparam int FN_DIR_BIT = 27; // Direction select, word bit 08
  localparam logic [2:0] FN_BYTE_XFER = 3'h6; // Byte transfer code
  localparam logic FN_DIR_OUT = 1'h0; // Outbound direction
  localparam logic [15:0] ADR_STEP_BYTE = 16'h0001;
  localparam logic [15:0] ADR_STEP_WORD = 16'h0002;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack; // Processor supplies the byte
    logic par; // Parity of the item
    logic [35:0] data; // Processor data bus
  } tts_pbus_in_t;
  typedef struct packed {
    logic req; // Bus-master write request
    logic byte_wr; // Byte-wide write
    logic [17:0] addr; // Host byte address
    logic [15:0] data; // Write data
  } tts_dma_out_t;
endpackage
`default_nettype wire

// file: test/ten_to_eleven_transfer_sequencer_tb_top.sv
/*
  Self-checking bench for the outbound sequencer: table of transfers,
  then reset, parity and unmapped cases. Assumes tts_partner beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module ten_to_eleven_transfer_sequencer_tb_top;
  import tts_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] dly, cnt, adr, item, dat;
    logic bw;
    logic [15:0] nadr;
  } tts_row_t;
  logic clk, sys_rst, avs_read, avs_write, fn_req, dma_ack, host_irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, bad_par, clr_cnt;
  logic [35:0] fn_word;
  tts_pbus_in_t pbus_in;
  tts_dma_out_t dma_out, last_wr;
  logic [7:0] wr_cnt;
  logic [2:0] lat;
  tts_row_t cur;
  int failures, check_count, cyc, gap;
  tts_row_t rows [5] = '{
    '{16'h7FFE, 16'h3FFF, 16'h1000, 16'h005A, 16'h005A, 1'b1, 16'h1001},
    '{16'hBFFD, 16'h3FFF, 16'h1001, 16'h00A5, 16'hA500, 1'b1, 16'h1002},
    '{16'h3FFF, 16'h1FFF, 16'h2000, 16'h1234, 16'h1234, 1'b0, 16'h2002},
    '{16'h3FFE, 16'h7FFD, 16'h1003, 16'h0000, 16'h0000, 1'b1, 16'h1003},
    '{16'h3FFE, 16'h3FFF, 16'h1003, 16'h0041, 16'h4100, 1'b1, 16'h1004}};
  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  tts_core tts_core_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pbus_in(pbus_in), .fn_req(fn_req), .fn_word(fn_word),
    .dma_out(dma_out), .dma_ack(dma_ack), .host_irq(host_irq));
  tts_partner tts_partner_inst (.clk(clk), .sys_rst(sys_rst),
    .fn_req(fn_req), .dma_out(dma_out), .item(cur.item),
    .byte_mode(cur.cnt[13]), .bad_par(bad_par), .lat(lat),
    .clr_cnt(clr_cnt), .pbus_in(pbus_in), .dma_ack(dma_ack),
    .last_wr_ff(last_wr), .wr_cnt_ff(wr_cnt));
  // ---------------------------------------------------------------
  // Clock, timeout and tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task check(input string name, input logic [35:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // One Avalon cycle; held until waitrequest is seen low at a rising edge
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    // Same edge: read data taken, request released
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task summarize();
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Run one transfer from a table row and judge the outcome
  task run_row(input tts_row_t r, input logic [2:0] l);
    cur = r;
    lat <= l;
    av(1'b1, SLOT_DLY, {16'h0000, r.dly});
    av(1'b1, SLOT_CNT, {16'h0000, r.cnt});
    av(1'b1, SLOT_ADR, {16'h0000, r.adr});
    av(1'b1, REG_STAT, 32'h0000_0003);
    clr_cnt <= 1'b1;
    @(posedge clk);
    clr_cnt <= 1'b0;
    av(1'b1, REG_CTRL, 32'h0000_0001);
    gap = 0;
    while (fn_req !== 1'b1) begin
      @(negedge clk);
      gap++;
    end
    // Delay-inc takes N+1 cycles; idle, two loads, count-inc and the look
    // that sees the request add five more
    check("pacing", gap == int'(14'(14'h0 - r.dly[13:0])) + 6, 1'b1);
    check("fn_word", fn_word, 36'h1_8000_0000);
    while (host_irq !== 1'b1) @(negedge clk);
    check("writes", wr_cnt, 8'h01);
    check("addr", last_wr.addr, {r.dly[15:14], r.adr});
    check("data", last_wr.data, r.dat);
    check("bytewr", last_wr.byte_wr, r.bw);
    av(1'b0, SLOT_ADR, 32'h0);
    check("next_adr", q[15:0], r.nadr);
    av(1'b0, SLOT_DAT, 32'h0);
    check("slot13", q[15:0], r.dat);
    av(1'b0, SLOT_CNT, 32'h0);
    check("count", q[12:0], 13'(r.cnt[12:0] + 13'h0001));
    av(1'b0, REG_STAT, 32'h0);
    check("status", q[3:0], {r.cnt[13], 1'b0, bad_par, 1'b1});
    av(1'b0, REG_CTRL, 32'h0);
    check("run", q[0], 1'b0);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {avs_read, avs_write, bad_par, clr_cnt} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    lat = 3'h0;
    cur = rows[0];
    failures = 0;
    check_count = 0;
    cyc = 0;
    sys_rst = 1'b1;
    repeat (9) @(posedge clk);
    @(negedge clk);
    check("rst_rdata", avs_readdata, 32'h0);
    check("rst_irq", host_irq, 1'b0);
    check("rst_fn", fn_req, 1'b0);
    check("rst_req", dma_out.req, 1'b0);
    check("rst_wait", avs_waitrequest, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    // Row 3 stops on a null, row 4 resumes with a fresh count
    for (int i = 0; i < 5; i++) run_row(rows[i], 3'(i));
    // Corrupted parity must be flagged, then cleared by software
    bad_par <= 1'b1;
    run_row(rows[0], 3'h2);
    bad_par <= 1'b0;
    av(1'b1, REG_STAT, 32'h0000_0003);
    av(1'b0, REG_STAT, 32'h0);
    check("stat_clr", q[1:0], 2'h0);
    check("irq_clr", host_irq, 1'b0);
    av(1'b1, 5'h1F, 32'hFFFF_FFFF);
    av(1'b0, 5'h1F, 32'h0);
    check("unmapped", q, 32'h0);
    // Reset in mid-transfer brings fetch, write request, wait and interrupt back to idle
    av(1'b1, SLOT_CNT, 32'h0000_3FFF);
    av(1'b1, REG_CTRL, 32'h0000_0001);
    while (fn_req !== 1'b1) @(negedge clk);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(negedge clk);
    check("mid_fn", fn_req, 1'b0);
    check("mid_req", dma_out.req, 1'b0);
    check("mid_wait", avs_waitrequest, 1'b1);
    check("mid_irq", host_irq, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    av(1'b0, REG_STAT, 32'h0);
    check("mid_stat", q[3:0], 4'h0);
    av(1'b0, REG_CTRL, 32'h0);
    check("mid_run", q[0], 1'b0);
    summarize();
  end
endmodule
`default_nettype wire

// file: test/tts_partner.sv
/*
  Far-side model: processor bus answering the fetch request, and host
  memory answering the bus-master write. Assumes the core's clk and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tts_partner
  import tts_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fn_req,
  input wire tts_dma_out_t dma_out,
  input wire logic [15:0] item,
  input wire logic byte_mode,
  input wire logic bad_par,
  input wire logic [2:0] lat,
  input wire logic clr_cnt,
  output tts_pbus_in_t pbus_in,
  output logic dma_ack,
  output tts_dma_out_t last_wr_ff,
  output logic [7:0] wr_cnt_ff
);
  // ---------------------------------------------------------------
  // Answer logic
  // ---------------------------------------------------------------
  logic [2:0] wait_ff; // Answer delay, shared: fetch and write never overlap
  // Released data lines toggle so a stale capture cannot pass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pbus_in <= '0;
      dma_ack <= 1'b0;
      wait_ff <= 3'h0;
    end else begin
      pbus_in.ack <= 1'b0;
      pbus_in.data <= ~pbus_in.data;
      dma_ack <= 1'b0;
      if ((fn_req && !pbus_in.ack) || (dma_out.req && !dma_ack)) begin
        wait_ff <= wait_ff + 3'h1;
        if (wait_ff == lat) begin
          wait_ff <= 3'h0;
          if (fn_req) begin
            pbus_in.ack <= 1'b1;
            pbus_in.par <= ^item ^ bad_par;
            // Junk above bit 15 must never reach the RAM
            pbus_in.data <= {20'hABCDE, byte_mode ? {8'h00, item[7:0]} :
                             item};
          end else begin
            dma_ack <= 1'b1;
          end
        end
      end
    end
  end
  // Record each taken host write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_cnt_ff <= 8'h00;
      last_wr_ff <= '0;
    end else if (clr_cnt) begin
      wr_cnt_ff <= 8'h00;
      last_wr_ff <= '0;
    end else if (dma_ack && dma_out.req) begin
      wr_cnt_ff <= wr_cnt_ff + 8'h01;
      last_wr_ff <= dma_out;
    end
  end
endmodule
`default_nettype wire
